// >>> host_port.sv
// data fifo and the sram-style host port with straps and interrupt pin
// assumes host pins are asynchronous and fifo far sides run on clk_i
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic ready_q, ready_d, valid_q, valid_d;
   logic push, pop;
   assign push = in_valid_i && ready_q;
   assign pop = out_ready_i && valid_q;
   always_comb begin
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = in_data_i;
         wr_d = (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = (rd_q == LAST) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
      ready_d = (cnt_d != FULL);
      valid_d = (cnt_d != '0);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         ready_q <= 1'b1;
         valid_q <= 1'b0;
      end else begin
         mem_q <= mem_d;
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         ready_q <= ready_d;
         valid_q <= valid_d;
      end
   end

   assign in_ready_o = ready_q;
   assign out_valid_o = valid_q;
   assign out_data_o = mem_q[rd_q];
endmodule

`timescale 1ns/1ps
module host_port #(
   parameter int FIFO_DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [host_port_pkg::DATA_W-1:0] data_i,
   output logic [host_port_pkg::DATA_W-1:0] data_o,
   output logic data_oe_n_o,
   input wire logic [host_port_pkg::ADDR_W-1:0] addr_i,
   input wire logic read_strobe_n_i,
   input wire logic write_strobe_n_i,
   input wire logic chip_select_n_i,
   input wire logic fifo_select_i,
   input wire logic speed_strap_i,
   input wire logic crossover_enable_strap_i,
   input wire logic big_endian_i,
   input wire logic irq_active_high_i,
   input wire logic irq_open_drain_i,
   input wire logic [host_port_pkg::SRC_W-1:0] irq_source_en_i,
   input wire logic sleep_req_i,
   output logic irq_o,
   output logic irq_oe_n_o,
   output logic awake_o,
   output logic link_speed_100_o,
   output logic link_full_duplex_o,
   output logic link_autoneg_o,
   output logic crossover_en_o,
   output logic [host_port_pkg::DATA_W-1:0] tx_data_o,
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   input wire logic [host_port_pkg::DATA_W-1:0] rx_data_i,
   input wire logic rx_valid_i,
   output logic rx_ready_o
);
   import host_port_pkg::*;
   host_pins_s pins_raw, sync1_q, sync2_q;
   logic [1:0] strap1_q, strap2_q;
   logic cs, rd_go, wr_go, any_go;

   // pin synchronisers
   assign pins_raw = '{!chip_select_n_i, !read_strobe_n_i,
                       !write_strobe_n_i, fifo_select_i, addr_i, data_i};

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
         strap1_q <= '0;
         strap2_q <= '0;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
         strap1_q <= {speed_strap_i, crossover_enable_strap_i};
         strap2_q <= strap1_q;
      end
   end

   assign cs = sync2_q.cs;
   assign rd_go = cs && sync2_q.rd && !sync2_q.wr;
   assign wr_go = cs && sync2_q.wr && !sync2_q.rd;
   assign any_go = cs && (sync2_q.rd || sync2_q.wr);

   function automatic logic [DATA_W-1:0] order(input logic [DATA_W-1:0] w,
                                               input logic be);
      order = be ? {w[7:0], w[15:8]} : w;
   endfunction

   // strap capture, once, after the synchronisers have filled
   logic [SETTLE_W-1:0] settle_q, settle_d;
   logic taken_q, taken_d;
   link_cfg_s cfg_q, cfg_d;

   always_comb begin
      settle_d = {settle_q[SETTLE_W-2:0], 1'b1};
      taken_d = taken_q;
      cfg_d = cfg_q;
      if (settle_q[SETTLE_W-1] && !taken_q) begin
         taken_d = 1'b1;
         cfg_d = strap2_q[1] ? CFG_STRAP1 : CFG_STRAP0;
         cfg_d.crossover = strap2_q[0];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         settle_q <= '0;
         taken_q <= 1'b0;
         cfg_q <= CFG_STRAP0;
      end else begin
         settle_q <= settle_d;
         taken_q <= taken_d;
         cfg_q <= cfg_d;
      end
   end

   // data fifos
   logic [DATA_W-1:0] tx_in, rx_out;
   logic tx_push, tx_space, rx_avail, rx_pop;

   word_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_data_i(tx_in),
      .in_valid_i(tx_push),
      .in_ready_o(tx_space),
      .out_data_o(tx_data_o),
      .out_valid_o(tx_valid_o),
      .out_ready_i(tx_ready_i)
   );

   word_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rx_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_data_i(rx_data_i),
      .in_valid_i(rx_valid_i),
      .in_ready_o(rx_ready_o),
      .out_data_o(rx_out),
      .out_valid_o(rx_avail),
      .out_ready_i(rx_pop)
   );

   // power and host access sequencing
   pwr_state_e pwr_q, pwr_d;
   acc_state_e acc_q, acc_d;
   logic [ADDR_W-1:0] adr_q, adr_d;
   logic fsel_q, fsel_d;
   logic wr_open_q, wr_open_d;
   logic lost_q, lost_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic oe_n_q, oe_n_d;
   logic [DATA_W-1:0] status;
   logic to_rx, to_tx, wr_done;

   assign status = DATA_W'({lost_q, wr_open_q, pwr_q == PWR_ON, tx_space,
                            rx_avail, cfg_q.crossover, cfg_q.autoneg,
                            cfg_q.full_duplex, cfg_q.speed_100});
   // fifo select overrides decode, upper address ignored
   assign to_rx = sync2_q.fifo_sel || (sync2_q.addr == RX_DATA_IDX);
   assign to_tx = fsel_q || (adr_q == TX_DATA_IDX);
   assign wr_done = (acc_q == ACC_WRITE) && !any_go;
   assign tx_in = order(sync2_q.data, big_endian_i);
   assign tx_push = wr_done && wr_open_q && to_tx
                    && (pwr_q == PWR_ON);
   assign rx_pop = (acc_q == ACC_IDLE) && rd_go && to_rx && rx_avail;

   always_comb begin
      pwr_d = pwr_q;
      acc_d = acc_q;
      adr_d = adr_q;
      fsel_d = fsel_q;
      wr_open_d = wr_open_q;
      lost_d = lost_q;
      rdata_d = rdata_q;
      oe_n_d = oe_n_q;
      unique case (acc_q)
         ACC_IDLE: begin
            if (rd_go) begin
               acc_d = ACC_READ;
               oe_n_d = 1'b0;
               wr_open_d = 1'b1;
               if (to_rx) begin
                  rdata_d = rx_avail ? order(rx_out, big_endian_i) : ZERO_WORD;
               end else if (sync2_q.addr == BYTE_TEST_IDX) begin
                  rdata_d = order(BYTE_TEST_VAL, big_endian_i);
               end else if (sync2_q.addr == STATUS_IDX) begin
                  rdata_d = order(status, big_endian_i);
                  lost_d = 1'b0;
               end else begin
                  rdata_d = ZERO_WORD;
               end
            end else if (wr_go) begin
               acc_d = ACC_WRITE;
               adr_d = sync2_q.addr;
               fsel_d = sync2_q.fifo_sel;
               if (pwr_q == PWR_SAVE) begin
                  pwr_d = PWR_ON;
                  wr_open_d = 1'b0;
               end
            end
         end
         ACC_READ: begin
            if (!any_go) begin
               acc_d = ACC_IDLE;
               oe_n_d = 1'b1;
            end
         end
         ACC_WRITE: begin
            if (!any_go) begin
               acc_d = ACC_IDLE;
            end
         end
         default: begin
            acc_d = ACC_IDLE;
            oe_n_d = 1'b1;
         end
      endcase
      if (wr_done && wr_open_q && to_tx && !tx_space) begin
         lost_d = 1'b1;
      end
      if ((pwr_q == PWR_ON) && sleep_req_i && (acc_q == ACC_IDLE)
          && !any_go) begin
         pwr_d = PWR_SAVE;
         wr_open_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pwr_q <= PWR_ON;
         acc_q <= ACC_IDLE;
         adr_q <= '0;
         fsel_q <= 1'b0;
         wr_open_q <= 1'b0;
         lost_q <= 1'b0;
         rdata_q <= '0;
         oe_n_q <= 1'b1;
      end else begin
         pwr_q <= pwr_d;
         acc_q <= acc_d;
         adr_q <= adr_d;
         fsel_q <= fsel_d;
         wr_open_q <= wr_open_d;
         lost_q <= lost_d;
         rdata_q <= rdata_d;
         oe_n_q <= oe_n_d;
      end
   end

   // interrupt pin
   logic [SRC_W-1:0] src;
   logic irq_lvl, irq_q, irq_d, irq_oe_n_q, irq_oe_n_d;
   assign src[SRC_RX] = rx_avail;
   assign src[SRC_TX] = tx_space;
   always_comb begin
      irq_lvl = (|(src & irq_source_en_i)) ~^ irq_active_high_i;
      if (irq_open_drain_i) begin
         irq_d = 1'b0;
         irq_oe_n_d = irq_lvl;
      end else begin
         irq_d = irq_lvl;
         irq_oe_n_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
         irq_oe_n_q <= 1'b1;
      end else begin
         irq_q <= irq_d;
         irq_oe_n_q <= irq_oe_n_d;
      end
   end

   assign data_o = rdata_q;
   assign data_oe_n_o = oe_n_q;
   assign irq_o = irq_q;
   assign irq_oe_n_o = irq_oe_n_q;
   assign awake_o = (pwr_q == PWR_ON);
   assign link_speed_100_o = cfg_q.speed_100;
   assign link_full_duplex_o = cfg_q.full_duplex;
   assign link_autoneg_o = cfg_q.autoneg;
   assign crossover_en_o = cfg_q.crossover;
endmodule

// >>> host_port_pkg.sv
// constants, field layouts and carriers for the host port block
// assumes one 125 MHz clock and an asynchronous active-high reset
// What this block does
// - a 7-bit word address selects the status words and the two data fifos.
// - strobes count only while chip select is low.
// - a qualified write strobe brings the port out of power saving.
// - one interrupt output with selectable polarity, sources and drive type.
// - with fifo select high every access goes to the data fifos.
// - with fifo select high the upper address bits are not decoded.
// - the speed strap is caught once just after reset release and held.
// - strap 0 gives 10M half duplex no autoneg, strap 1 100M half autoneg.
// - the crossover strap high enables automatic crossover, low disables it.
package host_port_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 16;
   localparam int SRC_W = 2;
   localparam logic [ADDR_W-1:0] RX_DATA_IDX = 7'h00;
   localparam logic [ADDR_W-1:0] TX_DATA_IDX = 7'h10;
   localparam logic [ADDR_W-1:0] BYTE_TEST_IDX = 7'h32;
   localparam logic [ADDR_W-1:0] STATUS_IDX = 7'h34;
   localparam logic [DATA_W-1:0] BYTE_TEST_VAL = 16'h4321;
   localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
   localparam int ST_SPEED = 0;
   localparam int ST_DUPLEX = 1;
   localparam int ST_AUTONEG = 2;
   localparam int ST_XOVER = 3;
   localparam int ST_RX_AVAIL = 4;
   localparam int ST_TX_SPACE = 5;
   localparam int ST_AWAKE = 6;
   localparam int ST_WR_OPEN = 7;
   localparam int ST_TX_LOST = 8;
   localparam int SRC_RX = 0;
   localparam int SRC_TX = 1;
   localparam int SETTLE_W = 2;

   typedef struct packed {
      logic cs;
      logic rd;
      logic wr;
      logic fifo_sel;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } host_pins_s;

   typedef struct packed {
      logic speed_100;
      logic full_duplex;
      logic autoneg;
      logic crossover;
   } link_cfg_s;

   localparam link_cfg_s CFG_STRAP0 = '{1'b0, 1'b0, 1'b0, 1'b0};
   localparam link_cfg_s CFG_STRAP1 = '{1'b1, 1'b0, 1'b1, 1'b0};

   typedef enum logic [2:0] {
      ACC_IDLE = 3'b001,
      ACC_READ = 3'b010,
      ACC_WRITE = 3'b100
   } acc_state_e;

   typedef enum logic [1:0] {
      PWR_ON = 2'b01,
      PWR_SAVE = 2'b10
   } pwr_state_e;
endpackage

// >>> host_port_chk_assertions.sv
// pin timing, strap and irq drive checks for host_port
// bound to every host_port; sees only its ports
`timescale 1ns/1ps
module host_port_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic data_oe_n_o,
   input wire logic read_strobe_n_i,
   input wire logic write_strobe_n_i,
   input wire logic chip_select_n_i,
   input wire logic speed_strap_i,
   input wire logic crossover_enable_strap_i,
   input wire logic irq_open_drain_i,
   input wire logic irq_o,
   input wire logic irq_oe_n_o,
   input wire logic awake_o,
   input wire logic link_speed_100_o,
   input wire logic link_full_duplex_o,
   input wire logic link_autoneg_o,
   input wire logic crossover_en_o
);
   logic [2:0] cnt_d;
   logic [2:0] cnt_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // edges since reset release, saturating
   always_comb begin
      cnt_d = (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 3'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   property p_rd_answer;
      $fell(data_oe_n_o) |-> $past(!chip_select_n_i && !read_strobe_n_i
         && write_strobe_n_i, 3);
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("bus driven without a qualified read");
   property p_rd_release;
      ($rose(read_strobe_n_i) && !data_oe_n_o) |-> ##[1:4] data_oe_n_o;
   endproperty
   a_rd_release: assert property (p_rd_release)
      else $error("bus not released after read");
   property p_wake;
      (!awake_o && !chip_select_n_i && !write_strobe_n_i && read_strobe_n_i)
         |-> ##[1:6] awake_o;
   endproperty
   a_wake: assert property (p_wake)
      else $error("qualified write did not wake");
   property p_strap_val;
      cnt_q == 3'h5 |-> (link_speed_100_o == speed_strap_i)
         && (crossover_en_o == crossover_enable_strap_i);
   endproperty
   a_strap_val: assert property (p_strap_val)
      else $error("strap not captured");
   property p_strap_hold;
      cnt_q >= 3'h4 |-> $stable(link_speed_100_o) && $stable(crossover_en_o)
         && $stable(link_autoneg_o);
   endproperty
   a_strap_hold: assert property (p_strap_hold)
      else $error("captured strap changed");
   property p_table;
      !link_full_duplex_o && (link_speed_100_o == link_autoneg_o);
   endproperty
   a_table: assert property (p_table)
      else $error("default link setting off table");
   property p_irq_od;
      (cnt_q >= 3'h2 && irq_open_drain_i && $past(irq_open_drain_i))
         |-> irq_o == 1'b0;
   endproperty
   a_irq_od: assert property (p_irq_od)
      else $error("open drain irq drives high");
   property p_irq_pp;
      (cnt_q >= 3'h2 && !irq_open_drain_i && !$past(irq_open_drain_i))
         |-> irq_oe_n_o == 1'b0;
   endproperty
   a_irq_pp: assert property (p_irq_pp)
      else $error("push pull irq not driven");
endmodule
bind host_port host_port_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
   .data_oe_n_o(data_oe_n_o), .read_strobe_n_i(read_strobe_n_i),
   .write_strobe_n_i(write_strobe_n_i), .chip_select_n_i(chip_select_n_i),
   .speed_strap_i(speed_strap_i),
   .crossover_enable_strap_i(crossover_enable_strap_i),
   .irq_open_drain_i(irq_open_drain_i), .irq_o(irq_o),
   .irq_oe_n_o(irq_oe_n_o), .awake_o(awake_o),
   .link_speed_100_o(link_speed_100_o),
   .link_full_duplex_o(link_full_duplex_o),
   .link_autoneg_o(link_autoneg_o), .crossover_en_o(crossover_en_o));

// >>> host_model.sv
// host cpu model running one sram-style access at a time
// pins move on falling edges; the bench resolves the data bus
`timescale 1ns/1ps
module host_model (
   input wire logic clk_i,
   input wire logic [host_port_pkg::DATA_W-1:0] bus_i,
   output host_port_pkg::host_pins_s pins_o
);
   import host_port_pkg::*;
   initial begin
      pins_o = '0;
   end
   task automatic acc(input logic wr, input logic fs,
      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      output logic [DATA_W-1:0] q);
      @(negedge clk_i);
      pins_o.cs = 1'b1;
      pins_o.rd = !wr;
      pins_o.wr = wr;
      pins_o.fifo_sel = fs;
      pins_o.addr = a;
      pins_o.data = wr ? d : ~pins_o.data;
      // released lines toggle so stale data never matches
      for (int i = 0; i < 6; i++) begin
         @(negedge clk_i);
         if (!wr) pins_o.data = ~pins_o.data;
      end
      q = bus_i;
      pins_o.cs = 1'b0;
      pins_o.rd = 1'b0;
      pins_o.wr = 1'b0;
      // write data held 4 clk, strobes high 4 clk
      for (int i = 0; i < 4; i++) begin
         @(negedge clk_i);
         if (!wr || i == 3) pins_o.data = ~pins_o.data;
      end
   endtask
endmodule

// >>> tb_top.sv
// self-checking bench for host_port driven through host_model
// needs the package, design, checker and host model compiled first
`timescale 1ns/1ps
module tb_top;
   import host_port_pkg::*;
   typedef struct packed {
      logic fs;
      logic be;
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] q;
   } row_s;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   host_pins_s pins;
   logic [DATA_W-1:0] bus, data_o, tx_data_o, rd_q;
   logic [DATA_W-1:0] rx_data_i = 16'h0000;
   logic data_oe_n_o, irq_o, irq_oe_n_o, awake_o, tx_valid_o, rx_ready_o;
   logic link_speed_100_o, link_full_duplex_o, link_autoneg_o, crossover_en_o;
   logic speed_strap_i = 1'b1, crossover_enable_strap_i = 1'b1;
   logic big_endian_i = 1'b0, irq_active_high_i = 1'b1;
   logic irq_open_drain_i = 1'b0, sleep_req_i = 1'b0;
   logic tx_ready_i = 1'b0, rx_valid_i = 1'b0;
   logic [SRC_W-1:0] irq_source_en_i = 2'h2;
   logic [1:0] irq_exp [4] = '{2'b00, 2'b00, 2'b10, 2'b01};
   int n_mismatch = 0;
   int checked = 0;
   row_s rows [5] = '{'{1'b0, 1'b0, 7'h32, 16'h4321},
      '{1'b0, 1'b1, 7'h32, 16'h2143}, '{1'b0, 1'b0, 7'h33, 16'h0000},
      '{1'b0, 1'b0, 7'h34, 16'h00ed}, '{1'b1, 1'b0, 7'h34, 16'h0000}};
   assign bus = data_oe_n_o ? pins.data : data_o;
   host_model i_host_model (.clk_i(clk_i), .bus_i(bus), .pins_o(pins));
   host_port i_host_port (.clk_i(clk_i), .rst_i(rst_i), .data_i(bus),
      .data_o(data_o), .data_oe_n_o(data_oe_n_o), .addr_i(pins.addr),
      .read_strobe_n_i(!pins.rd), .write_strobe_n_i(!pins.wr),
      .chip_select_n_i(!pins.cs), .fifo_select_i(pins.fifo_sel),
      .speed_strap_i(speed_strap_i),
      .crossover_enable_strap_i(crossover_enable_strap_i),
      .big_endian_i(big_endian_i), .irq_active_high_i(irq_active_high_i),
      .irq_open_drain_i(irq_open_drain_i), .irq_source_en_i(irq_source_en_i),
      .sleep_req_i(sleep_req_i), .irq_o(irq_o), .irq_oe_n_o(irq_oe_n_o),
      .awake_o(awake_o), .link_speed_100_o(link_speed_100_o),
      .link_full_duplex_o(link_full_duplex_o),
      .link_autoneg_o(link_autoneg_o), .crossover_en_o(crossover_en_o),
      .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
      .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o));
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   task automatic check(input logic [DATA_W:0] seen,
      input logic [DATA_W:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic do_reset(input logic sp, input logic xo);
      @(negedge clk_i);
      rst_i = 1'b1;
      speed_strap_i = sp;
      crossover_enable_strap_i = xo;
      repeat (12) @(negedge clk_i);
      check({data_oe_n_o, awake_o, tx_valid_o, rx_ready_o}, 4'hd);
      rst_i = 1'b0;
      repeat (6) @(negedge clk_i);
   endtask
   initial begin
      #160000;
      n_mismatch++;
      give_verdict;
   end
   initial begin
      do_reset(1'b1, 1'b1);
      check({link_speed_100_o, link_full_duplex_o, link_autoneg_o,
         crossover_en_o}, 4'hb);
      for (int i = 0; i < 5; i++) begin
         big_endian_i = rows[i].be;
         i_host_model.acc(1'b0, rows[i].fs, rows[i].a, 16'h0000, rd_q);
         check(rd_q, rows[i].q);
      end
      big_endian_i = 1'b0;
      for (int i = 0; i < 4; i++) begin
         {irq_active_high_i, irq_open_drain_i} = 2'(i);
         repeat (2) @(negedge clk_i);
         check({irq_o, irq_oe_n_o}, irq_exp[i]);
      end
      irq_open_drain_i = 1'b0;
      irq_source_en_i = 2'h1;
      repeat (2) @(negedge clk_i);
      check({irq_o, irq_oe_n_o}, 2'b00);
      do_reset(1'b0, 1'b0);
      check({link_speed_100_o, link_full_duplex_o, link_autoneg_o,
         crossover_en_o}, 4'h0);
      i_host_model.acc(1'b1, 1'b0, TX_DATA_IDX, 16'haaaa, rd_q);
      check(tx_valid_o, 1'b0);
      i_host_model.acc(1'b0, 1'b0, BYTE_TEST_IDX, 16'h0000, rd_q);
      big_endian_i = 1'b1;
      i_host_model.acc(1'b1, 1'b0, TX_DATA_IDX, 16'h1234, rd_q);
      big_endian_i = 1'b0;
      // tx stalled: fill through fifo select, last word refused
      for (int i = 1; i < 5; i++) begin
         i_host_model.acc(1'b1, 1'b1, 7'h7f, 16'h0a00 + 16'(i), rd_q);
      end
      i_host_model.acc(1'b0, 1'b0, STATUS_IDX, 16'h0000, rd_q);
      check(rd_q, 16'h01c0);
      tx_ready_i = 1'b1;
      for (int i = 0; i < 4; i++) begin
         check({tx_valid_o, tx_data_o},
            {1'b1, i == 0 ? 16'h3412 : 16'h0a00 + 16'(i)});
         @(negedge clk_i);
      end
      check(tx_valid_o, 1'b0);
      tx_ready_i = 1'b0;
      rx_valid_i = 1'b1;
      for (int i = 0; i < 4; i++) begin
         rx_data_i = 16'h5500 + 16'(i);
         @(negedge clk_i);
      end
      rx_valid_i = 1'b0;
      check({rx_ready_o, irq_o, irq_oe_n_o}, 3'b010);
      for (int i = 0; i < 5; i++) begin
         i_host_model.acc(1'b0, i[0], i[0] ? 7'h7e : RX_DATA_IDX,
            16'h0000, rd_q);
         check(rd_q, i < 4 ? 16'h5500 + 16'(i) : 16'h0000);
      end
      sleep_req_i = 1'b1;
      @(negedge clk_i);
      sleep_req_i = 1'b0;
      @(negedge clk_i);
      check(awake_o, 1'b0);
      i_host_model.acc(1'b1, 1'b0, BYTE_TEST_IDX, 16'h0000, rd_q);
      check(awake_o, 1'b1);
      i_host_model.acc(1'b1, 1'b0, TX_DATA_IDX, 16'h0bad, rd_q);
      check(tx_valid_o, 1'b0);
      i_host_model.acc(1'b0, 1'b0, STATUS_IDX, 16'h0000, rd_q);
      i_host_model.acc(1'b1, 1'b0, TX_DATA_IDX, 16'h0c0d, rd_q);
      check({tx_valid_o, tx_data_o}, {1'b1, 16'h0c0d});
      give_verdict;
   end
endmodule
